// ---- i2c_host_control_regs_tb_top.sv ----
// self-checking bench for the two-wire host control block
`timescale 1ns/1ps
module i2c_host_control_regs_tb_top;
	import i2chc_pkg::*;
	typedef struct packed {
		logic [3:0] x;
		logic [7:0] e;
		logic [7:0] m;
	} i2chc_note_t;
	localparam logic [6:0] CADDR = 7'h2A;
	localparam int         TBASE = 20;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, cpu_halted_i, gie_i, irq_read_o, irq_write_o;
	logic        dual_active_o, client_fast_plus_o, scl_o, scl_oe_o, sda_o, sda_oe_o, cl_oe;
	logic [1:0]  client_hold_sel_o;
	logic [3:0]  sel_i;
	logic [7:0]  adr_i, rd, d, rd_byte, last_rx;
	logic [31:0] dat_i, dat_o;
	wire         scl_w = ~scl_oe_o;
	wire         sda_w = ~(sda_oe_o | cl_oe);
	i2chc_note_t notes[$];
	i2chc_note_t nt;
	int          err_total, checked, lim;

	i2chc_top #(.TOUT_BASE_CYCLES(TBASE)) i2chc_top_inst (.*, .scl_i(scl_w), .sda_i(sda_w));
	i2chc_client_model #(.ADDR(CADDR)) i2chc_client_model_inst (
		.scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(cl_oe), .rd_byte_i(rd_byte), .last_rx_o(last_rx));

	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic hang(input logic [3:0] x, input logic [7:0] e);
		err_total++;
		$display("FAIL wait_reg_%0h expected %h seen %h", x, e, rd);
		end_of_test();
	endtask
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	// one classic cycle; a read leaves its expectation for the monitor
	task automatic wb(input logic w, input logic [3:0] x, input logic [7:0] v, input logic [7:0] e, input logic [7:0] m);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= {2'h0, x, 2'h0};
		dat_i <= {24'h000000, v};
		if (!w)
			notes.push_back('{x, e, m});
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20)
			hang(x, 8'h00);
		rd = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] x, input logic [7:0] v);
		wb(1'b1, x, v, 8'h00, 8'h00);
	endtask
	task automatic rdc(input logic [3:0] x, input logic [7:0] e, input logic [7:0] m);
		wb(1'b0, x, 8'h00, e, m);
	endtask
	task automatic poll(input logic [3:0] x, input logic [7:0] m, input logic [7:0] v);
		int n;
		n = 0;
		do begin
			rdc(x, 8'h00, 8'h00);
			n++;
		end while ((rd & m) !== v && n < 600);
		if (n >= 600)
			hang(x, v);
	endtask
	task automatic cw(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic do_reset();
		rst_i <= 1'b1;
		cw(2);
		rst_i <= 1'b0;
	endtask

	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && notes.size() > 0) begin
			nt = notes.pop_front();
			if (nt.m !== 8'h00) begin
				checked++;
				if (((dat_o[7:0] ^ nt.e) & nt.m) !== 8'h00) begin
					err_total++;
					$display("FAIL reg_%0h expected %h seen %h", nt.x, nt.e & nt.m, dat_o[7:0] & nt.m);
				end
			end
		end
	end

	initial begin
		cw(100000);
		hang(4'h0, 8'h00);
	end

	initial begin
		{rst_i, cyc_i, stb_i, we_i, cpu_halted_i, gie_i} = 6'h20;
		{adr_i, dat_i, sel_i, err_total, checked} = '0;
		sel_i = 4'hF;
		rd_byte = 8'h80 | 8'($urandom(32'hB0BD));
		cw(2);
		rst_i <= 1'b0;
		for (int i = 1; i <= 5; i++)
			rdc(4'(i), 8'h00, 8'hFF);
		wr(4'hC, 8'hFF);
		rdc(4'hC, 8'h00, 8'hFF);
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			d = {4'($urandom()), 2'(i >> 1), 1'($urandom()), 1'(i)};
			wr(4'h1, d);
			rdc(4'h1, d, 8'h0F);
			cw(3);
			chk("client", {4'h0, d[0] ? d[3:2] : 2'h0, d[1] & d[0], d[0]}, {4'h0, client_hold_sel_o, client_fast_plus_o, dual_active_o});
		end
		wr(4'h1, 8'h00);
		d = 8'($urandom()) & 8'hDE;
		wr(4'h3, d);
		rdc(4'h3, d, 8'hDF);
		wr(4'h4, 8'h07);
		rdc(4'h4, 8'h04, 8'h0F);
		$display("test registers done");
		wr(4'h3, 8'hC1);
		gie_i <= 1'b1;
		wr(4'h5, 8'h01);
		rdc(4'h5, 8'h01, 8'h03);
		wr(4'h7, {CADDR, 1'b0});
		poll(4'h5, 8'h40, 8'h40);
		rdc(4'h5, 8'h62, 8'hF3);
		chk("irq_write", 8'h01, {7'h0, irq_write_o});
		gie_i <= 1'b0;
		cw(3);
		chk("irq_write", 8'h00, {7'h0, irq_write_o});
		gie_i <= 1'b1;
		d = 8'($urandom());
		wr(4'h8, d);
		poll(4'h5, 8'h40, 8'h40);
		chk("client_rx", d, last_rx);
		wr(4'h4, 8'h06);
		cw(60);
		rdc(4'h5, 8'h00, 8'h60);
		d = 8'($urandom());
		wr(4'h8, d);
		poll(4'h5, 8'h40, 8'h40);
		chk("client_rx", d, last_rx);
		wr(4'h4, 8'h03);
		poll(4'h5, 8'h03, 8'h01);
		$display("test host write done");
		wr(4'h7, {CADDR, 1'b1});
		poll(4'h5, 8'h80, 8'h80);
		chk("irq_read", 8'h01, {7'h0, irq_read_o});
		rdc(4'h8, rd_byte, 8'hFF);
		rdc(4'h5, 8'h00, 8'h80);
		wr(4'h4, 8'h02);
		poll(4'h5, 8'h80, 8'h80);
		wr(4'h5, 8'h80);
		rdc(4'h5, 8'h00, 8'h80);
		wr(4'h3, 8'hC3);
		wr(4'h4, 8'h04);
		rdc(4'h8, rd_byte, 8'hFF);
		poll(4'h5, 8'h03, 8'h01);
		$display("test host read done");
		wr(4'h3, 8'h11);
		wr(4'h7, {CADDR, 1'b1});
		poll(4'h5, 8'hC0, 8'h80);
		wr(4'h4, 8'h03);
		poll(4'h5, 8'h03, 8'h01);
		$display("test quick command done");
		wr(4'h3, 8'h01);
		wr(4'h7, {CADDR, 1'b0});
		cw(30);
		wr(4'h4, 8'h08);
		cw(4);
		chk("line_drive", 8'h00, {6'h0, scl_oe_o, sda_oe_o});
		rdc(4'h5, 8'h01, 8'h23);
		wr(4'h7, {CADDR, 1'b0});
		poll(4'h5, 8'h40, 8'h40);
		d = 8'($urandom());
		wr(4'h8, d);
		poll(4'h5, 8'h40, 8'h40);
		chk("client_rx", d, last_rx);
		wr(4'h4, 8'h03);
		poll(4'h5, 8'h03, 8'h01);
		$display("test flush done");
		cpu_halted_i <= 1'b1;
		wr(4'h7, {CADDR, 1'b0});
		cw(60);
		rdc(4'h5, 8'h01, 8'h43);
		wr(4'h2, 8'h01);
		wr(4'h7, {CADDR, 1'b0});
		poll(4'h5, 8'h40, 8'h40);
		cpu_halted_i <= 1'b0;
		wr(4'h4, 8'h03);
		poll(4'h5, 8'h03, 8'h01);
		$display("test debug halt done");
		for (int c = 0; c < 4; c++) begin
			do_reset();
			wr(4'h3, {4'h0, 2'(c), 2'h1});
			cw(TBASE / 2);
			rdc(4'h5, 8'h00, 8'h03);
			lim = (c == 0) ? 160 : (TBASE << (c - 1)) * 2;
			cw(lim);
			rdc(4'h5, (c == 0) ? 8'h00 : 8'h01, 8'h03);
		end
		$display("test timeout done");
		cw(4);
		end_of_test();
	end
endmodule

// ---- i2chc_client_model.sv ----
// behavioural client on the two-wire bus: acks its address, takes written bytes, serves reads
`timescale 1ns/1ps
module i2chc_client_model #(
	parameter logic [6:0] ADDR = 7'h2A
) (
	// wired bus levels and the client's pull-down
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_oe_o,
	// byte served on reads, last byte taken on writes
	input  wire logic [7:0] rd_byte_i,
	output logic      [7:0] last_rx_o
);
	logic       busy;
	logic       addr_ph;
	logic       mt;
	logic       rd;
	logic [7:0] sr;
	logic [7:0] tx;
	int         cnt;

	initial begin
		{sda_oe_o, busy, rd, mt} = 4'h0;
		last_rx_o = 8'h00;
	end
	// start and stop are data edges while the clock is high
	always @(negedge sda_i) if (scl_i === 1'b1) begin
		busy    = 1'b1;
		addr_ph = 1'b1;
		rd      = 1'b0;
		cnt     = 0;
	end
	always @(posedge sda_i) if (scl_i === 1'b1) begin
		busy     = 1'b0;
		rd       = 1'b0;
		sda_oe_o = 1'b0;
	end
	always @(posedge scl_i) if (busy) begin
		sr  = {sr[6:0], sda_i};
		cnt = cnt + 1;
	end
	// data only changes while the clock is low
	always @(negedge scl_i) if (busy) begin
		sda_oe_o = 1'b0;
		if (cnt == 8 && addr_ph) begin
			addr_ph  = 1'b0;
			mt       = (sr[7:1] == ADDR);
			rd       = mt & sr[0];
			sda_oe_o = mt;
		end else if (cnt == 8 && mt && !rd) begin
			last_rx_o = sr;
			sda_oe_o  = 1'b1;
		end else if (cnt == 9) begin
			cnt = 0;
			rd  = rd & ~sr[0];
			tx  = rd_byte_i;
		end
		if (rd && cnt < 8)
			sda_oe_o = ~tx[7 - cnt];
	end
endmodule

// ---- i2chc_params.svh ----
// register offsets, field positions, reset values and timing figures of the two-wire host block
`ifndef I2CHC_PARAMS_SVH
`define I2CHC_PARAMS_SVH

// register indices; byte address is four times the index
`define I2CHC_IDX_DUAL      4'h1
`define I2CHC_IDX_DBG       4'h2
`define I2CHC_IDX_HCTL      4'h3
`define I2CHC_IDX_HCMD      4'h4
`define I2CHC_IDX_HSTAT     4'h5
`define I2CHC_IDX_BAUD      4'h6
`define I2CHC_IDX_HADDR     4'h7
`define I2CHC_IDX_HDATA     4'h8

// field positions
`define I2CHC_CMD_FLUSH_BIT 3
`define I2CHC_CMD_ACK_BIT   2
`define I2CHC_ST_RIF_BIT    7
`define I2CHC_ST_WIF_BIT    6
`define I2CHC_ST_HOLD_BIT   5
`define I2CHC_DBG_RUN_BIT   0

// reset values
`define I2CHC_RST_BYTE      8'h00

// timing
`define I2CHC_CLK_MHZ       25
`define I2CHC_TOUT_BASE_US  50
`define I2CHC_BAUD_OFFSET   9'h005

`endif

// ---- i2chc_pkg.sv ----
// types shared by the two-wire host control block
package i2chc_pkg;

	typedef enum logic [3:0] {
		E_IDLE  = 4'h0,
		E_START = 4'h1,
		E_LO    = 4'h3,
		E_HI    = 4'h2,
		E_HOLD  = 4'h6,
		E_RST   = 4'h7,
		E_STOP  = 4'h5
	} i2chc_state_t;

	typedef enum logic [1:0] {
		K_TX    = 2'h0,
		K_RXACK = 2'h1,
		K_RX    = 2'h2,
		K_TXACK = 2'h3
	} i2chc_kind_t;

	typedef enum logic [1:0] {
		BS_UNKNOWN = 2'h0,
		BS_IDLE    = 2'h1,
		BS_OWNER   = 2'h2,
		BS_BUSY    = 2'h3
	} i2chc_bus_t;

	typedef enum logic [1:0] {
		C_NO_ACTION_CODE  = 2'h0,
		C_RSTART = 2'h1,
		C_XFER   = 2'h2,
		C_STOP   = 2'h3
	} i2chc_cmd_t;

	typedef struct packed {
		logic       rsv1;
		logic       rsv0;
		logic       rsv;
		logic       rsvx;
		logic [1:0] client_hold;
		logic       fast_plus;
		logic       en;
	} i2chc_dual_t;

	typedef struct packed {
		logic       read_irq_enable;
		logic       write_irq_enable;
		logic       rsv;
		logic       quick_command_enable;
		logic [1:0] timeout;
		logic       smart_ack_enable;
		logic       en;
	} i2chc_hctl_t;

	typedef struct packed {
		logic       addr;
		logic       data;
		logic       cmd;
		logic       smart;
		i2chc_cmd_t code;
		logic       ack;
		logic [7:0] wval;
	} i2chc_req_t;

endpackage

// ---- i2chc_top.sv ----
// two-wire host: register file on classic Wishbone and the bit-level host engine
// How it works
// - with dual control on, client hold select drives client hold time; else ignored.
// - fast-plus select sets client to 1 MHz only while dual control is on.
// - bit zero of dual mode control turns dual control on.
// - halted and run-while-halted clear: engine freezes, bus events ignored.
// - read irq only when read enable, read-done flag and global enable are set.
// - write irq only when write enable, write-done flag and global enable are set.
// - quick command: client ack of address sets read or write flag by direction.
// - nonzero timeout field forces bus idle after 50, 100 or 200 us inactivity.
// - smart mode: reading host data sends stored ack action at once.
// - bit zero of host control primary enables the host.
// - flush writes give one-cycle strobe resetting host, bus state goes idle.
// - ack action 0 ACK, 1 NACK; sent on smart read or command, never data write.
// - command field is a write strobe, reads zero, each write of a nonzero code starts an operation.
// - codes: 1 ack then repeated start, 2 ack then byte transfer, 3 ack then stop.
// - host write command waits for new host data before sending the byte.
// - one write may set ack action and command; new ack used for it.
// - read-done flag sets when a host byte read completes.
// - read-done clears on write-one, address write, data access, command write.
// - write-done sets after address or byte write; clears like read-done.
// - clock-stretch flag reads one while host holds clock low; clears like read-done.
// - line state field reports unknown, idle, owner or busy.
// - host address write issues start and sends address, bit zero as direction.
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "i2chc_params.svh"

module i2chc_top
	import i2chc_pkg::*;
#(
	parameter int TOUT_BASE_CYCLES = `I2CHC_TOUT_BASE_US * `I2CHC_CLK_MHZ
) (
	// system
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// processor status
	input  wire logic        cpu_halted_i,
	input  wire logic        gie_i,
	// interrupt requests
	output logic             irq_read_o,
	output logic             irq_write_o,
	// client configuration
	output logic             dual_active_o,
	output logic      [1:0]  client_hold_sel_o,
	output logic             client_fast_plus_o,
	// bus pins, open drain
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o
);

	initial begin
		if (TOUT_BASE_CYCLES < 1 || TOUT_BASE_CYCLES > 16383) begin
			$error("TOUT_BASE_CYCLES out of range");
		end
	end

	localparam logic [15:0] TOUT1 = 16'(TOUT_BASE_CYCLES);
	localparam logic [15:0] TOUT2 = 16'(TOUT_BASE_CYCLES * 2);
	localparam logic [15:0] TOUT4 = 16'(TOUT_BASE_CYCLES * 4);

	// registers
	i2chc_dual_t  dual_q;
	logic         run_halt_q;
	i2chc_hctl_t  hctl_q;
	logic         ack_action_select_q;
	logic [7:0]   baud_q;
	logic [7:0]   haddr_q;
	logic         rif_q;
	logic         wif_q;
	logic         hold_q;
	logic         rxack_q;
	i2chc_bus_t   bus_q;
	logic         ack_q;
	logic [31:0]  dat_q;
	logic         flush_q;
	i2chc_req_t   req_q;

	// engine
	i2chc_state_t st_q;
	i2chc_kind_t  kind_q;
	i2chc_cmd_t   nxt_q;
	logic [15:0]  cnt_q;
	logic [1:0]   ph_q;
	logic [2:0]   bitn_q;
	logic [7:0]   sh_q;
	logic         addr_ph_q;
	logic         txack_q;
	logic         pend_q;
	logic         scl_oe_q;
	logic         sda_oe_q;
	logic         ev_rif_q;
	logic         ev_wif_q;
	logic         ev_hold_q;

	// pin sync
	logic         scl_m_q;
	logic         scl_s_q;
	logic         scl_p_q;
	logic         sda_m_q;
	logic         sda_s_q;
	logic         sda_p_q;
	logic [15:0]  idle_cnt_q;

	logic [3:0]   idx;
	logic         acc;
	logic         wr;
	logic         rd;
	logic         halted;
	logic         frz;
	logic         clr_flags;
	logic         wstat;
	logic [8:0]   half;
	logic         half_done;
	logic [15:0]  tout_lim;

	assign idx    = adr_i[5:2];
	assign acc    = cyc_i && stb_i && !ack_q;
	assign wr     = acc && we_i && sel_i[0];
	assign rd     = acc && !we_i;
	assign wstat  = wr && idx == `I2CHC_IDX_HSTAT;
	assign halted = cpu_halted_i;
	assign frz    = cpu_halted_i && !run_halt_q;

	// data accesses never trigger while halted, even with run-while-halted set
	assign clr_flags = req_q.addr || req_q.data || req_q.cmd || req_q.smart;

	assign half      = `I2CHC_BAUD_OFFSET + {1'b0, baud_q};
	assign half_done = cnt_q >= {7'h00, half};

	// wishbone: ack one cycle after the request, dropped the next cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= acc;
			if (rd) begin
				case (idx)
					`I2CHC_IDX_DUAL:  dat_q <= {24'h000000, dual_q};
					`I2CHC_IDX_DBG:   dat_q <= {31'h00000000, run_halt_q};
					`I2CHC_IDX_HCTL:  dat_q <= {24'h000000, hctl_q};
					`I2CHC_IDX_HCMD:  dat_q <= {29'h00000000, ack_action_select_q, 2'h0};
					`I2CHC_IDX_HSTAT: dat_q <= {24'h000000, rif_q, wif_q, hold_q, rxack_q, 2'h0, bus_q};
					`I2CHC_IDX_BAUD:  dat_q <= {24'h000000, baud_q};
					`I2CHC_IDX_HADDR: dat_q <= {24'h000000, haddr_q};
					`I2CHC_IDX_HDATA: dat_q <= {24'h000000, sh_q};
					default:          dat_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// control registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dual_q     <= i2chc_dual_t'(`I2CHC_RST_BYTE);
			run_halt_q <= 1'b0;
			hctl_q     <= i2chc_hctl_t'(`I2CHC_RST_BYTE);
			ack_action_select_q   <= 1'b0;
			baud_q     <= `I2CHC_RST_BYTE;
			haddr_q    <= `I2CHC_RST_BYTE;
		end else if (wr) begin
			case (idx)
				`I2CHC_IDX_DUAL:  dual_q     <= i2chc_dual_t'({4'h0, dat_i[3:0]});
				`I2CHC_IDX_DBG:   run_halt_q <= dat_i[`I2CHC_DBG_RUN_BIT];
				`I2CHC_IDX_HCTL:  hctl_q     <= i2chc_hctl_t'({dat_i[7:6], 1'b0, dat_i[4:0]});
				`I2CHC_IDX_HCMD:  ack_action_select_q   <= dat_i[`I2CHC_CMD_ACK_BIT];
				`I2CHC_IDX_BAUD:  baud_q     <= dat_i[7:0];
				`I2CHC_IDX_HADDR: haddr_q    <= dat_i[7:0];
				default: ;
			endcase
		end
	end

	// strobes toward the engine, one cycle after the access
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			req_q   <= '0;
			flush_q <= 1'b0;
		end else begin
			flush_q     <= wr && idx == `I2CHC_IDX_HCMD && dat_i[`I2CHC_CMD_FLUSH_BIT];
			req_q.addr  <= wr && idx == `I2CHC_IDX_HADDR && !frz;
			req_q.data  <= wr && idx == `I2CHC_IDX_HDATA && !halted;
			req_q.cmd   <= wr && idx == `I2CHC_IDX_HCMD && dat_i[1:0] != 2'h0 && !frz;
			req_q.smart <= rd && idx == `I2CHC_IDX_HDATA && !halted;
			req_q.code  <= i2chc_cmd_t'(dat_i[1:0]);
			req_q.ack   <= (wr && idx == `I2CHC_IDX_HCMD) ? dat_i[`I2CHC_CMD_ACK_BIT] : ack_action_select_q;
			req_q.wval  <= dat_i[7:0];
		end
	end

	// status flags; a hardware set wins over any clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rif_q  <= 1'b0;
			wif_q  <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			if (ev_rif_q) begin
				rif_q <= 1'b1;
			end else if (clr_flags || (wstat && dat_i[`I2CHC_ST_RIF_BIT])) begin
				rif_q <= 1'b0;
			end
			if (ev_wif_q) begin
				wif_q <= 1'b1;
			end else if (clr_flags || (wstat && dat_i[`I2CHC_ST_WIF_BIT])) begin
				wif_q <= 1'b0;
			end
			if (ev_hold_q) begin
				hold_q <= 1'b1;
			end else if (clr_flags || flush_q || !hctl_q.en || (wstat && dat_i[`I2CHC_ST_HOLD_BIT])) begin
				hold_q <= 1'b0;
			end
		end
	end

	// interrupt requests
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{irq_read_o, irq_write_o} <= 2'h0;
		end else begin
			irq_read_o  <= hctl_q.read_irq_enable && rif_q && gie_i;
			irq_write_o <= hctl_q.write_irq_enable && wif_q && gie_i;
		end
	end

	// client settings only reach the client side under dual control
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{dual_active_o, client_hold_sel_o, client_fast_plus_o} <= 4'h0;
		end else begin
			dual_active_o      <= dual_q.en;
			client_hold_sel_o  <= dual_q.en ? dual_q.client_hold : 2'h0;
			client_fast_plus_o <= dual_q.en && dual_q.fast_plus;
		end
	end

	// pin synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q} <= 6'h3F;
		end else begin
			scl_m_q <= scl_i;
			scl_s_q <= scl_m_q;
			scl_p_q <= scl_s_q;
			sda_m_q <= sda_i;
			sda_s_q <= sda_m_q;
			sda_p_q <= sda_s_q;
		end
	end

	always_comb begin
		case (hctl_q.timeout)
			2'h1:    tout_lim = TOUT1;
			2'h2:    tout_lim = TOUT2;
			2'h3:    tout_lim = TOUT4;
			default: tout_lim = 16'hFFFF;
		endcase
	end

	// line state monitor with inactivity supervisor
	always_ff @(posedge clk_i) begin
		if (rst_i || !hctl_q.en) begin
			bus_q      <= BS_UNKNOWN;
			idle_cnt_q <= 16'h0000;
		end else if (!frz) begin
			if (scl_s_q != scl_p_q || sda_s_q != sda_p_q) begin
				idle_cnt_q <= 16'h0000;
			end else if (idle_cnt_q != 16'hFFFF) begin
				idle_cnt_q <= idle_cnt_q + 16'h0001;
			end
			if (scl_s_q && scl_p_q && sda_p_q && !sda_s_q) begin
				bus_q <= (st_q == E_START || st_q == E_RST) ? BS_OWNER : BS_BUSY;
			end else if (scl_s_q && scl_p_q && !sda_p_q && sda_s_q) begin
				bus_q <= BS_IDLE;
			end else if (flush_q) begin
				bus_q <= BS_IDLE;
			end else if (hctl_q.timeout != 2'h0 && bus_q != BS_IDLE && idle_cnt_q >= tout_lim) begin
				bus_q <= BS_IDLE;
			end else if (wstat && dat_i[1:0] == 2'h1) begin
				bus_q <= BS_IDLE;
			end
		end
	end

	// host engine; data changes two cycles after the clock falls so no false start/stop
	always_ff @(posedge clk_i) begin
		if (rst_i || flush_q || !hctl_q.en) begin
			st_q      <= E_IDLE;
			kind_q    <= K_TX;
			nxt_q     <= C_NO_ACTION_CODE;
			{cnt_q, ph_q, bitn_q, sh_q} <= 29'h0000_0000;
			{addr_ph_q, txack_q, pend_q, scl_oe_q, sda_oe_q, rxack_q} <= 6'h00;
			{ev_rif_q, ev_wif_q, ev_hold_q} <= 3'h0;
		end else begin
			{ev_rif_q, ev_wif_q, ev_hold_q} <= 3'h0;
			if (req_q.data) begin
				sh_q <= req_q.wval;
			end
			if (!frz) begin
				case (st_q)
					E_IDLE: begin
						cnt_q <= 16'h0000;
						if (req_q.addr) begin
							pend_q <= 1'b1;
						end else if (pend_q && bus_q == BS_IDLE) begin
							pend_q   <= 1'b0;
							sda_oe_q <= 1'b1;
							st_q     <= E_START;
						end
					end
					E_START: begin
						cnt_q <= cnt_q + 16'h0001;
						if (half_done) begin
							scl_oe_q  <= 1'b1;
							sh_q      <= haddr_q;
							kind_q    <= K_TX;
							bitn_q    <= 3'h7;
							addr_ph_q <= 1'b1;
							cnt_q     <= 16'h0000;
							st_q      <= E_LO;
						end
					end
					E_LO: begin
						cnt_q <= cnt_q + 16'h0001;
						if (cnt_q == 16'h0001) begin
							case (kind_q)
								K_TX:    sda_oe_q <= !sh_q[7];
								K_TXACK: sda_oe_q <= !txack_q;
								default: sda_oe_q <= 1'b0;
							endcase
						end
						if (half_done) begin
							scl_oe_q <= 1'b0;
							cnt_q    <= 16'h0000;
							st_q     <= E_HI;
						end
					end
					E_HI: begin
						// clock stretched by a client holds the count
						if (scl_s_q) begin
							cnt_q <= cnt_q + 16'h0001;
						end
						if (scl_s_q && half_done) begin
							scl_oe_q <= 1'b1;
							cnt_q    <= 16'h0000;
							st_q     <= E_LO;
							case (kind_q)
								K_TX: begin
									sh_q <= {sh_q[6:0], 1'b0};
									if (bitn_q == 3'h0) begin
										kind_q <= K_RXACK;
									end else begin
										bitn_q <= bitn_q - 3'h1;
									end
								end
								K_RX: begin
									sh_q <= {sh_q[6:0], sda_s_q};
									if (bitn_q == 3'h0) begin
										ev_rif_q  <= 1'b1;
										ev_hold_q <= 1'b1;
										st_q      <= E_HOLD;
									end else begin
										bitn_q <= bitn_q - 3'h1;
									end
								end
								K_RXACK: begin
									rxack_q   <= sda_s_q;
									addr_ph_q <= 1'b0;
									if (addr_ph_q && hctl_q.quick_command_enable && !sda_s_q) begin
										ev_rif_q  <= haddr_q[0];
										ev_wif_q  <= !haddr_q[0];
										ev_hold_q <= 1'b1;
										st_q      <= E_HOLD;
									end else if (addr_ph_q && haddr_q[0] && !sda_s_q) begin
										kind_q <= K_RX;
										bitn_q <= 3'h7;
									end else begin
										ev_wif_q  <= 1'b1;
										ev_hold_q <= 1'b1;
										st_q      <= E_HOLD;
									end
								end
								default: begin
									case (nxt_q)
										C_RSTART: st_q <= E_RST;
										C_STOP:   st_q <= E_STOP;
										default: begin
											kind_q <= K_RX;
											bitn_q <= 3'h7;
										end
									endcase
								end
							endcase
						end
					end
					E_HOLD: begin
						cnt_q <= 16'h0000;
						if (req_q.addr) begin
							st_q <= E_RST;
						end else if (req_q.data && !haddr_q[0]) begin
							kind_q <= K_TX;
							bitn_q <= 3'h7;
							st_q   <= E_LO;
						end else if (req_q.cmd && haddr_q[0]) begin
							kind_q  <= K_TXACK;
							txack_q <= req_q.ack;
							nxt_q   <= req_q.code;
							st_q    <= E_LO;
						end else if (req_q.cmd && req_q.code == C_RSTART) begin
							st_q <= E_RST;
						end else if (req_q.cmd && req_q.code == C_STOP) begin
							st_q <= E_STOP;
						end else if (req_q.smart && hctl_q.smart_ack_enable && haddr_q[0]) begin
							kind_q  <= K_TXACK;
							txack_q <= ack_action_select_q;
							nxt_q   <= ack_action_select_q ? C_STOP : C_XFER;
							st_q    <= E_LO;
						end
						// write-direction transfer code waits here for new data
					end
					E_RST: begin
						if (ph_q != 2'h1 || scl_s_q) begin
							cnt_q <= cnt_q + 16'h0001;
						end
						if (ph_q == 2'h0 && cnt_q == 16'h0001) begin
							sda_oe_q <= 1'b0;
						end
						if (half_done && (ph_q != 2'h1 || scl_s_q)) begin
							cnt_q <= 16'h0000;
							ph_q  <= ph_q + 2'h1;
							case (ph_q)
								2'h0:    scl_oe_q <= 1'b0;
								2'h1:    sda_oe_q <= 1'b1;
								default: begin
									ph_q      <= 2'h0;
									scl_oe_q  <= 1'b1;
									sh_q      <= haddr_q;
									kind_q    <= K_TX;
									bitn_q    <= 3'h7;
									addr_ph_q <= 1'b1;
									st_q      <= E_LO;
								end
							endcase
						end
					end
					E_STOP: begin
						if (ph_q == 2'h0 || scl_s_q) begin
							cnt_q <= cnt_q + 16'h0001;
						end
						if (ph_q == 2'h0 && cnt_q == 16'h0001) begin
							sda_oe_q <= 1'b1;
						end
						if (half_done && (ph_q == 2'h0 || scl_s_q)) begin
							cnt_q <= 16'h0000;
							if (ph_q == 2'h0) begin
								scl_oe_q <= 1'b0;
								ph_q     <= 2'h1;
							end else begin
								sda_oe_q <= 1'b0;
								ph_q     <= 2'h0;
								st_q     <= E_IDLE;
							end
						end
					end
					default: st_q <= E_IDLE;
				endcase
			end
		end
	end

	// open drain: only ever pull low
	assign scl_o    = 1'b0;
	assign sda_o    = 1'b0;
	assign scl_oe_o = scl_oe_q;
	assign sda_oe_o = sda_oe_q;

endmodule

// ---- i2chc_top_sva.sv ----
// concurrent checks on the ports of the two-wire host block
`timescale 1ns/1ps
module i2chc_top_sva
	import i2chc_pkg::*;
#(
	parameter int TOUT_BASE_CYCLES = 1250
) (
	// system and bus slave
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [7:0]  adr_i,
	input wire logic [3:0]  sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	// processor, interrupts, client outputs
	input wire logic        cpu_halted_i,
	input wire logic        gie_i,
	input wire logic        irq_read_o,
	input wire logic        irq_write_o,
	input wire logic        dual_active_o,
	input wire logic [1:0]  client_hold_sel_o,
	input wire logic        client_fast_plus_o,
	// bus pins
	input wire logic        scl_i,
	input wire logic        scl_o,
	input wire logic        scl_oe_o,
	input wire logic        sda_i,
	input wire logic        sda_o,
	input wire logic        sda_oe_o
);
	logic take;
	logic wr0;
	logic en_q;
	logic read_irq_enable_q;
	logic write_irq_enable_q;
	logic run_q;

	assign take = cyc_i & stb_i & ~ack_o;
	assign wr0  = take & we_i & sel_i[0];
	// shadows of control bits, seen only through bus writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{en_q, read_irq_enable_q, write_irq_enable_q, run_q} <= 4'h0;
		end else if (wr0 && adr_i[5:2] == 4'h3) begin
			{read_irq_enable_q, write_irq_enable_q, en_q} <= {dat_i[7:6], dat_i[0]};
		end else if (wr0 && adr_i[5:2] == 4'h2) begin
			run_q <= dat_i[0];
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_ack_next; take |=> ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_single; ack_o |=> !ack_o; endproperty
	a_ack_single: assert property (p_ack_single) else $error("ack long");
	property p_cmd_reads_zero; take && !we_i && adr_i[5:2] == 4'h4 |=> dat_o[3] == 1'b0 && dat_o[1:0] == 2'h0; endproperty
	a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("strobe read");
	property p_hold_ignored; !dual_active_o |-> client_hold_sel_o == 2'h0; endproperty
	a_hold_ignored: assert property (p_hold_ignored) else $error("hold select");
	property p_fast_plus; client_fast_plus_o |-> dual_active_o; endproperty
	a_fast_plus: assert property (p_fast_plus) else $error("fast plus");
	property p_dual_enable; wr0 && adr_i[5:2] == 4'h1 |-> ##2 dual_active_o == $past(dat_i[0], 2); endproperty
	a_dual_enable: assert property (p_dual_enable) else $error("dual enable");
	property p_irq_read; !read_irq_enable_q || !gie_i |=> !irq_read_o; endproperty
	a_irq_read: assert property (p_irq_read) else $error("read irq");
	property p_irq_write; !write_irq_enable_q || !gie_i |=> !irq_write_o; endproperty
	a_irq_write: assert property (p_irq_write) else $error("write irq");
	property p_halt_freeze; (cpu_halted_i && !run_q) [*3] |-> $stable(scl_oe_o) && $stable(sda_oe_o); endproperty
	a_halt_freeze: assert property (p_halt_freeze) else $error("halt moved");
	property p_flush_release;
		wr0 && adr_i[5:2] == 4'h4 && dat_i[3] && dat_i[1:0] == 2'h0 |-> ##[2:5] !scl_oe_o && !sda_oe_o;
	endproperty
	a_flush_release: assert property (p_flush_release) else $error("flush held");
	property p_disable_release; (!en_q) [*4] |-> !scl_oe_o && !sda_oe_o; endproperty
	a_disable_release: assert property (p_disable_release) else $error("off held");

	c_irq_read: cover property (irq_read_o);
	c_flush: cover property (wr0 && adr_i[5:2] == 4'h4 && dat_i[3]);
	c_halt_run: cover property (cpu_halted_i && run_q && scl_oe_o);
endmodule

bind i2chc_top i2chc_top_sva #(.TOUT_BASE_CYCLES(TOUT_BASE_CYCLES)) i2chc_top_sva_inst (.*);
